/* pin_sync3.sv */
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Raw and filtered levels.
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] level_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] level_r;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge sys_clk_i) begin
				if (srst_i) begin
					s1_r[i] <= RST_VAL[i];
					s2_r[i] <= RST_VAL[i];
					s3_r[i] <= RST_VAL[i];
					level_r[i] <= RST_VAL[i];
				end else begin
					s1_r[i] <= async_i[i];
					s2_r[i] <= s1_r[i];
					s3_r[i] <= s2_r[i];
					if (s2_r[i] == s3_r[i]) begin
						level_r[i] <= s3_r[i];
					end
				end
			end
		end
	endgenerate

	assign level_o = level_r;
endmodule
`default_nettype wire

/* prom_array_model.sv */
// Behavioural PROM array that programs a byte while held and powered and answers CPU reads.
`timescale 1ns/1ns
`default_nettype none
module prom_array_model #(
	parameter logic [7:0] ERASED = 8'hff
) (
	// Clock.
	input wire logic sys_clk_i,
	// Array controls from the block.
	input wire logic [12:0] prom_addr_i,
	input wire logic [7:0] prom_data_i,
	input wire logic prom_hold_i,
	input wire logic prom_rd_en_i,
	input wire logic vpp_en_i,
	// Read data back to the CPU.
	output logic [7:0] rd_data_o
);
	logic [7:0] cells [8192];
	logic [7:0] last_r = 8'h00;
	initial begin
		for (int i = 0; i < 8192; i++) begin
			cells[i] = ERASED;
		end
	end
	// Programming only clears bits of an erased cell, so a second pulse cannot restore ones.
	always @(posedge sys_clk_i) begin
		if (prom_hold_i && vpp_en_i) begin
			cells[prom_addr_i] <= cells[prom_addr_i] & prom_data_i;
		end
		if (prom_rd_en_i) begin
			last_r <= rd_data_o;
		end
	end
	// A released data bus shows the inverse of the last byte, so a stale value never passes for a read.
	always_comb begin
		if (prom_rd_en_i && !prom_hold_i) begin
			rd_data_o = cells[prom_addr_i];
		end else begin
			rd_data_o = ~last_r;
		end
	end
endmodule
`default_nettype wire

/* prom_ctrl_pkg.sv */
// Shared constants and types for the PROM programming and option control block.
package prom_ctrl_pkg;
	localparam int REG_ADDR_W = 4;
	localparam int MEM_ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int SYNC_STAGES = 3;
	// Register offsets on the register port.
	localparam logic [3:0] WRITE_CTRL_OFS = 4'h0;
	localparam logic [3:0] OPTION_OFS = 4'h1;
	// Field positions in prom_write_control.
	localparam int ARM_BIT = 2;
	localparam int VPP_BIT = 0;
	// Field positions in memory_and_irq_options.
	localparam int LOW_SEL_BIT = 7;
	localparam int PAGE_SEL_BIT = 6;
	localparam int SEC_BIT = 3;
	localparam int FACTORY_BIT = 2;
	localparam int IRQ_SENS_BIT = 1;
	// Values after reset.
	localparam logic ARM_RST = 1'b0;
	localparam logic VPP_RST = 1'b0;
	localparam logic LOW_SEL_RST = 1'b0;
	localparam logic PAGE_SEL_RST = 1'b0;
	localparam logic IRQ_SENS_RST = 1'b1;
	localparam logic FACTORY_RD_VAL = 1'b0;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam logic [12:0] PROM_ADDR_RST = 13'h0000;
	localparam logic [7:0] PROM_DATA_RST = 8'h00;
	// Inputs synchronised from pins: irq_n, sec_fuse, boot_mode.
	localparam logic [2:0] PIN_SYNC_RST = 3'h1;
	// Memory map boundaries.
	localparam logic [12:0] LOW_PROM_LO = 13'h0020;
	localparam logic [12:0] LOW_RAM_LO = 13'h0030;
	localparam logic [12:0] LOW_HI = 13'h005f;
	localparam logic [12:0] PAGE_LO = 13'h0100;
	localparam logic [12:0] PAGE_HI = 13'h015f;
	localparam logic [12:0] PROM_MAIN_LO = 13'h0160;
	typedef enum logic [1:0] {
		REG_OTHER,
		REG_PROM,
		REG_RAM,
		REG_UNUSED
	} region_t;
endpackage

/* prom_program_and_option_ctrl.sv */
// PROM write control, memory map options, security and external interrupt sensitivity.
`timescale 1ns/1ns
`default_nettype none
module prom_program_and_option_ctrl (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Register port.
	input wire logic [3:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// CPU memory access.
	input wire logic [12:0] mem_addr_i,
	input wire logic [7:0] mem_wdata_i,
	input wire logic mem_wr_i,
	input wire logic mem_rd_i,
	// PROM array side.
	output logic [12:0] prom_addr_o,
	output logic [7:0] prom_data_o,
	output logic prom_hold_o,
	output logic prom_rd_en_o,
	output logic vpp_en_o,
	// Memory map decode.
	output var prom_ctrl_pkg::region_t region_o,
	// Pins and fuse.
	input wire logic sec_fuse_i,
	input wire logic boot_mode_i,
	input wire logic irq_n_i,
	input wire logic irq_ack_i,
	output logic security_on_o,
	output logic boot_loader_en_o,
	output logic irq_req_o
);
	logic arm_r;
	logic vpp_on_r;
	logic low_sel_r;
	logic page_sel_r;
	logic irq_sens_r;
	logic irq_wr_done_r;
	logic held_r;
	logic [12:0] prom_addr_r;
	logic [7:0] prom_data_r;
	logic prom_rd_en_r;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	prom_ctrl_pkg::region_t region_r;
	prom_ctrl_pkg::region_t region_nxt;
	logic prom_hit;
	logic [2:0] pins_f;
	logic irq_lvl;
	logic sec_f;
	logic boot_f;
	logic irq_prev_r;
	logic pin_fall;
	logic edge_pend_r;
	logic edge_pend_nxt;
	logic irq_req_r;
	logic sec_r;
	logic boot_en_r;
	logic wr_ctrl;
	logic wr_opt;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);

	assign wr_ctrl = reg_wr_i && (reg_addr_i == prom_ctrl_pkg::WRITE_CTRL_OFS);
	assign wr_opt = reg_wr_i && (reg_addr_i == prom_ctrl_pkg::OPTION_OFS);

	// Pin order: bit 0 interrupt pin, bit 1 fuse cell, bit 2 boot mode.
	pin_sync3 #(
		.W(3),
		.RST_VAL(prom_ctrl_pkg::PIN_SYNC_RST)
	) u_pin_sync (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.async_i({boot_mode_i, sec_fuse_i, irq_n_i}),
		.level_o(pins_f)
	);
	assign irq_lvl = pins_f[0];
	assign sec_f = pins_f[1];
	assign boot_f = pins_f[2];

	// Programming control bits.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			arm_r <= prom_ctrl_pkg::ARM_RST;
			vpp_on_r <= prom_ctrl_pkg::VPP_RST;
		end else if (wr_ctrl) begin
			arm_r <= reg_wdata_i[prom_ctrl_pkg::ARM_BIT];
			// The voltage bit only moves while already armed, so it cannot be set in the arming write.
			if (arm_r) begin
				vpp_on_r <= reg_wdata_i[prom_ctrl_pkg::VPP_BIT];
			end
		end
	end

	assign vpp_en_o = vpp_on_r;

	// Memory map options and write-once trigger select.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			low_sel_r <= prom_ctrl_pkg::LOW_SEL_RST;
			page_sel_r <= prom_ctrl_pkg::PAGE_SEL_RST;
			irq_sens_r <= prom_ctrl_pkg::IRQ_SENS_RST;
			irq_wr_done_r <= 1'b0;
		end else if (wr_opt) begin
			low_sel_r <= reg_wdata_i[prom_ctrl_pkg::LOW_SEL_BIT];
			page_sel_r <= reg_wdata_i[prom_ctrl_pkg::PAGE_SEL_BIT];
			irq_wr_done_r <= 1'b1;
			if (!irq_wr_done_r) begin
				irq_sens_r <= reg_wdata_i[prom_ctrl_pkg::IRQ_SENS_BIT];
			end
		end
	end

	// Address decode of the CPU access.
	always_comb begin
		region_nxt = prom_ctrl_pkg::REG_OTHER;
		if (mem_addr_i >= prom_ctrl_pkg::LOW_PROM_LO && mem_addr_i <= prom_ctrl_pkg::LOW_HI) begin
			if (!low_sel_r) begin
				region_nxt = prom_ctrl_pkg::REG_PROM;
			end else if (mem_addr_i < prom_ctrl_pkg::LOW_RAM_LO) begin
				region_nxt = prom_ctrl_pkg::REG_UNUSED;
			end else begin
				region_nxt = prom_ctrl_pkg::REG_RAM;
			end
		end else if (mem_addr_i >= prom_ctrl_pkg::PAGE_LO && mem_addr_i <= prom_ctrl_pkg::PAGE_HI) begin
			region_nxt = page_sel_r ? prom_ctrl_pkg::REG_RAM : prom_ctrl_pkg::REG_PROM;
		end else if (mem_addr_i >= prom_ctrl_pkg::PROM_MAIN_LO) begin
			region_nxt = prom_ctrl_pkg::REG_PROM;
		end
	end

	assign prom_hit = (region_nxt == prom_ctrl_pkg::REG_PROM);

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			region_r <= prom_ctrl_pkg::REG_OTHER;
		end else begin
			region_r <= region_nxt;
		end
	end

	assign region_o = region_r;

	// PROM bus capture: while armed, each PROM write is taken and then held until the next PROM write or disarm.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			prom_addr_r <= prom_ctrl_pkg::PROM_ADDR_RST;
			prom_data_r <= prom_ctrl_pkg::PROM_DATA_RST;
			held_r <= 1'b0;
		end else if (arm_r) begin
			if (mem_wr_i && prom_hit) begin
				prom_addr_r <= mem_addr_i;
				prom_data_r <= mem_wdata_i;
				held_r <= 1'b1;
			end
		end else begin
			prom_addr_r <= mem_addr_i;
			prom_data_r <= mem_wdata_i;
			held_r <= 1'b0;
		end
	end

	// PROM reads are served only while the buses are not held.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			prom_rd_en_r <= 1'b0;
		end else begin
			prom_rd_en_r <= mem_rd_i && prom_hit && !arm_r;
		end
	end

	assign prom_addr_o = prom_addr_r;
	assign prom_data_o = prom_data_r;
	assign prom_hold_o = arm_r;
	assign prom_rd_en_o = prom_rd_en_r;

	// Security and bootstrap loader enable.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			sec_r <= 1'b0;
			boot_en_r <= 1'b0;
		end else begin
			sec_r <= sec_f;
			boot_en_r <= boot_f && !sec_f;
		end
	end

	assign security_on_o = sec_r;
	assign boot_loader_en_o = boot_en_r;

	// External interrupt: edge latch plus optional low-level term.
	assign pin_fall = irq_prev_r && !irq_lvl;

	always_comb begin
		edge_pend_nxt = edge_pend_r;
		if (pin_fall) begin
			edge_pend_nxt = 1'b1;
		end else if (irq_ack_i) begin
			edge_pend_nxt = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			irq_prev_r <= 1'b1;
			edge_pend_r <= 1'b0;
			irq_req_r <= 1'b0;
		end else begin
			irq_prev_r <= irq_lvl;
			edge_pend_r <= edge_pend_nxt;
			irq_req_r <= edge_pend_nxt || (irq_sens_r && !irq_lvl);
		end
	end

	assign irq_req_o = irq_req_r;

	// Register read data, valid only in the cycle after the strobe.
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd_i) begin
			case (reg_addr_i)
				prom_ctrl_pkg::WRITE_CTRL_OFS: begin
					rdata_nxt[prom_ctrl_pkg::ARM_BIT] = arm_r;
					rdata_nxt[prom_ctrl_pkg::VPP_BIT] = vpp_on_r;
				end
				prom_ctrl_pkg::OPTION_OFS: begin
					rdata_nxt[prom_ctrl_pkg::LOW_SEL_BIT] = low_sel_r;
					rdata_nxt[prom_ctrl_pkg::PAGE_SEL_BIT] = page_sel_r;
					rdata_nxt[prom_ctrl_pkg::SEC_BIT] = sec_r;
					rdata_nxt[prom_ctrl_pkg::FACTORY_BIT] = prom_ctrl_pkg::FACTORY_RD_VAL;
					rdata_nxt[prom_ctrl_pkg::IRQ_SENS_BIT] = irq_sens_r;
				end
				default: begin
					rdata_nxt = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rdata_r <= prom_ctrl_pkg::RDATA_RST;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_o = rdata_r;

	sequence s_pin_fall;
		irq_prev_r && !irq_lvl;
	endsequence

	sequence s_armed_prom_write;
		arm_r && mem_wr_i && prom_hit;
	endsequence

	a_vpp_write_gate: assert property (wr_ctrl && !arm_r |=> vpp_on_r == $past(vpp_on_r))
		else $error("voltage bit changed while not armed");

	a_vpp_rise_armed: assert property ($rose(vpp_on_r) |-> $past(arm_r))
		else $error("voltage bit rose without prior arm");

	a_hold_capture: assert property (s_armed_prom_write |=> prom_addr_o == $past(mem_addr_i)
		&& prom_data_o == $past(mem_wdata_i) && prom_hold_o)
		else $error("armed PROM write not captured");

	a_hold_stable: assert property (arm_r && held_r && !(mem_wr_i && prom_hit) && !wr_ctrl
		|=> $stable(prom_addr_o) && $stable(prom_data_o))
		else $error("held PROM buses moved");

	a_read_blocked: assert property (mem_rd_i && prom_hit |=> prom_rd_en_o == !$past(arm_r))
		else $error("PROM read enable wrong for arm state");

	a_low_unused: assert property (low_sel_r && mem_addr_i >= 13'h0020 && mem_addr_i <= 13'h002f
		|=> region_o == prom_ctrl_pkg::REG_UNUSED)
		else $error("low unused area not decoded");

	a_low_map: assert property (mem_addr_i >= 13'h0030 && mem_addr_i <= 13'h005f
		|=> region_o == ($past(low_sel_r) ? prom_ctrl_pkg::REG_RAM : prom_ctrl_pkg::REG_PROM))
		else $error("low area decoded wrongly");

	a_page_map: assert property (mem_addr_i >= 13'h0100 && mem_addr_i <= 13'h015f
		|=> region_o == ($past(page_sel_r) ? prom_ctrl_pkg::REG_RAM : prom_ctrl_pkg::REG_PROM))
		else $error("page one decoded wrongly");

	a_low_write: assert property (wr_opt |=> low_sel_r == $past(reg_wdata_i[7])
		&& page_sel_r == $past(reg_wdata_i[6]))
		else $error("option select bits not written");

	a_trigger_once: assert property (irq_wr_done_r && wr_opt |=> $stable(irq_sens_r))
		else $error("trigger bit changed after first write");

	a_irq_level: assert property (irq_sens_r && !irq_lvl |=> irq_req_o)
		else $error("low level not requesting");

	a_irq_edge: assert property (s_pin_fall |=> irq_req_o ##1 (irq_req_o || $past(irq_ack_i)))
		else $error("falling edge lost");

	a_sec_boot: assert property (sec_f ##1 sec_f |=> security_on_o && !boot_loader_en_o)
		else $error("security did not block loader");

	a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data outside read slot");

	a_arm_write: assert property (wr_ctrl |=> arm_r == $past(reg_wdata_i[prom_ctrl_pkg::ARM_BIT]))
		else $error("arm bit not written");

	a_vpp_armed_write: assert property (wr_ctrl && arm_r
		|=> vpp_on_r == $past(reg_wdata_i[prom_ctrl_pkg::VPP_BIT]))
		else $error("voltage bit not written while armed");

	a_trigger_first: assert property (wr_opt && !irq_wr_done_r
		|=> irq_sens_r == $past(reg_wdata_i[prom_ctrl_pkg::IRQ_SENS_BIT]))
		else $error("first trigger write not taken");

	a_boot_open: assert property (boot_f && !sec_f |=> boot_loader_en_o)
		else $error("loader not enabled in boot mode");

	a_ctrl_readback: assert property (reg_rd_i && reg_addr_i == prom_ctrl_pkg::WRITE_CTRL_OFS
		|=> reg_rdata_o[prom_ctrl_pkg::ARM_BIT] == $past(arm_r)
		&& reg_rdata_o[prom_ctrl_pkg::VPP_BIT] == $past(vpp_on_r))
		else $error("control register read back wrong");
endmodule
`default_nettype wire

/* prom_program_and_option_ctrl_tb_top.sv */
// Self-checking bench for the PROM programming and option control block.
`timescale 1ns/1ns
`default_nettype none
module prom_program_and_option_ctrl_tb_top;
	logic clk, srst, reg_wr, reg_rd, mem_wr, mem_rd, prom_hold, prom_rd_en, vpp_en;
	logic sec_fuse, boot_mode, irq_n, irq_ack, security_on, boot_en, irq_req;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, mem_wdata, prom_data, model_data;
	logic [12:0] mem_addr, prom_addr;
	prom_ctrl_pkg::region_t region;
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	prom_program_and_option_ctrl u_prom_program_and_option_ctrl (.sys_clk_i(clk), .srst_i(srst),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .mem_wr_i(mem_wr),
		.mem_rd_i(mem_rd), .prom_addr_o(prom_addr), .prom_data_o(prom_data), .prom_hold_o(prom_hold),
		.prom_rd_en_o(prom_rd_en), .vpp_en_o(vpp_en), .region_o(region), .sec_fuse_i(sec_fuse),
		.boot_mode_i(boot_mode), .irq_n_i(irq_n), .irq_ack_i(irq_ack), .security_on_o(security_on),
		.boot_loader_en_o(boot_en), .irq_req_o(irq_req));
	prom_array_model u_prom_array_model (.sys_clk_i(clk), .prom_addr_i(prom_addr), .prom_data_i(prom_data),
		.prom_hold_i(prom_hold), .prom_rd_en_i(prom_rd_en), .vpp_en_i(vpp_en), .rd_data_o(model_data));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task summarize;
		if (errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors = errors + 1;
			summarize;
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe, then the port returns to zero.
	task rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
		@(posedge clk);
		#1;
		chk(reg_rdata, 8'h00);
	endtask
	task mw(input logic [12:0] a, input logic [7:0] d);
		@(posedge clk);
		mem_addr <= a;
		mem_wdata <= d;
		mem_wr <= 1'b1;
		@(posedge clk);
		mem_wr <= 1'b0;
		#1;
	endtask
	task mr(input logic [12:0] a);
		@(posedge clk);
		mem_addr <= a;
		mem_rd <= 1'b1;
		@(posedge clk);
		mem_rd <= 1'b0;
		#1;
	endtask
	task dec(input logic [12:0] a, input prom_ctrl_pkg::region_t exp);
		@(posedge clk);
		mem_addr <= a;
		@(posedge clk);
		#1;
		chk(region, exp);
	endtask
	task wait_req(input logic exp);
		for (int i = 0; i < 10 && irq_req !== exp; i++) begin
			@(posedge clk);
			#1;
		end
		chk(irq_req, exp);
	endtask
	task do_reset;
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
	endtask
	initial begin
		{reg_wr, reg_rd, mem_wr, mem_rd, irq_ack, sec_fuse} = '0;
		{reg_addr, reg_wdata, mem_addr, mem_wdata} = '0;
		{srst, irq_n, boot_mode} = 3'h7;
		do_reset;
		chk(region, prom_ctrl_pkg::REG_OTHER);
		chk(boot_en, 1'b1);
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h02);
		wr(4'h2, 8'hff);
		rd(4'h2, 8'h00);
		wr(4'h0, 8'h01);
		rd(4'h0, 8'h00);
		wr(4'h0, 8'h05);
		rd(4'h0, 8'h04);
		chk(prom_hold, 1'b1);
		mw(13'h0200, 8'ha5);
		chk(prom_addr, 16'h0200);
		chk(prom_data, 8'ha5);
		mw(13'h0005, 8'h11);
		chk(prom_addr, 16'h0200);
		chk(prom_data, 8'ha5);
		mr(13'h0200);
		chk(prom_rd_en, 1'b0);
		wr(4'h0, 8'h05);
		#1;
		chk(vpp_en, 1'b1);
		wr(4'h0, 8'h04);
		#1;
		chk(vpp_en, 1'b0);
		wr(4'h0, 8'h00);
		rd(4'h0, 8'h00);
		mr(13'h0200);
		chk(prom_rd_en, 1'b1);
		chk(model_data, 8'ha5);
		wr(4'h1, 8'h00);
		rd(4'h1, 8'h00);
		wr(4'h1, 8'hc2);
		rd(4'h1, 8'hc0);
		dec(13'h0020, prom_ctrl_pkg::REG_UNUSED);
		dec(13'h002f, prom_ctrl_pkg::REG_UNUSED);
		dec(13'h0030, prom_ctrl_pkg::REG_RAM);
		dec(13'h005f, prom_ctrl_pkg::REG_RAM);
		dec(13'h015f, prom_ctrl_pkg::REG_RAM);
		dec(13'h0010, prom_ctrl_pkg::REG_OTHER);
		wr(4'h1, 8'h00);
		dec(13'h0020, prom_ctrl_pkg::REG_PROM);
		dec(13'h0100, prom_ctrl_pkg::REG_PROM);
		dec(13'h0160, prom_ctrl_pkg::REG_PROM);
		irq_n <= 1'b0;
		wait_req(1'b1);
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(irq_req, 1'b0);
		irq_n <= 1'b1;
		sec_fuse <= 1'b1;
		do_reset;
		chk(security_on, 1'b1);
		chk(boot_en, 1'b0);
		rd(4'h1, 8'h0a);
		irq_n <= 1'b0;
		wait_req(1'b1);
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(irq_req, 1'b1);
		irq_n <= 1'b1;
		wait_req(1'b0);
		summarize;
	end
endmodule
`default_nettype wire
